/* slfc_top.sv */
`timescale 1ns/1ns
// Purpose: fault check, nmi masking and vector limit check of the core
// Assumes: check and delivery requests come from pclk logic, nmi from a pin
// Notes:   control and status reached over apb, zero wait states
module slfc_top
  import slfc_pkg::*;
#(
  parameter int ADDR_W  = 12,
  parameter int ENTRY_B = 8,
  parameter logic [7:0] DF_VECTOR = 8'h08
)(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // instruction check request
  input  wire logic              chk_valid,
  input  wire slfc_mode_t        chk_mode,
  input  wire slfc_instr_t       chk_instr,
  input  wire logic              chk_has_mem,
  input  wire logic [7:0]        chk_prefix,
  input  wire logic              chk_feature_ok,
  input  wire logic [1:0]        chk_mod_field,
  input  wire logic              chk_fpu_pending,
  input  wire logic              chk_stack_ref,
  input  wire logic              chk_seg_illegal,
  input  wire logic              chk_dst_nonwr,
  input  wire logic              chk_null_sel,
  input  wire logic              chk_noncanon,
  input  wire logic [31:0]       chk_addr,
  input  wire logic [3:0]        chk_size,
  input  wire logic              chk_flag_ac,
  input  wire logic              chk_unaligned,
  input  wire logic [1:0]        chk_cpl,
  input  wire logic              chk_page_fault,
  // check verdict
  output logic                   fault_valid,
  output slfc_fault_t            fault_kind,
  output logic                   fault_err_zero,
  // nmi pin and interrupt return
  input  wire logic              nmi_pin,
  input  wire logic              interrupt_return_instr_retire,
  output logic                   nmi_take,
  output logic                   nmi_blocked,
  // vector delivery
  input  wire logic              vec_req,
  input  wire logic [7:0]        vec_num,
  output logic                   vec_ok,
  output logic                   double_fault,
  output logic                   vec_busy,
  output logic                   shutdown
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // indexed by the bus bit numbers so reads, writes and taps agree
  logic [CTRL_AC_BIT:CTRL_EM_BIT] ctrl_q;
  logic [15:0]  idt_limit_q;
  logic [15:0]  fault_cnt_q;
  slfc_fault_t  last_fault_q;
  logic         pready_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic         fault_valid_q;
  slfc_fault_t  fault_kind_q;
  logic         fault_err_q;
  logic [2:0]   nmi_sync_q;
  logic         nmi_level_q;
  logic         nmi_blocked_q;
  logic         nmi_blocked_d;
  logic         nmi_pend_q;
  logic         nmi_take_q;
  logic         nmi_edge;
  slfc_dlv_t    dlv_q;
  slfc_dlv_t    dlv_d;
  logic [7:0]   vec_hold_q;
  logic         vec_ok_q;
  logic         df_q;
  logic         vec_busy_q;
  logic         shutdown_q;
  logic         apb_wr;
  logic         apb_setup;
  logic [31:0]  rd_word;
  logic         rd_hit;

  slfc_chk_if chk ();

  // ------------------------------------------------------------
  // check request fan-out and judge
  // ------------------------------------------------------------
  assign chk.mode               = chk_mode;
  assign chk.instr              = chk_instr;
  assign chk.has_mem            = chk_has_mem;
  assign chk.prefix             = chk_prefix;
  assign chk.feature_ok         = chk_feature_ok;
  assign chk.mod_field          = chk_mod_field;
  assign chk.emulation_flag     = ctrl_q[CTRL_EM_BIT];
  assign chk.task_switched_flag = ctrl_q[CTRL_TS_BIT];
  assign chk.fpu_pending        = chk_fpu_pending;
  assign chk.stack_ref          = chk_stack_ref;
  assign chk.seg_illegal        = chk_seg_illegal;
  assign chk.dst_nonwr          = chk_dst_nonwr;
  assign chk.null_sel           = chk_null_sel;
  assign chk.noncanon           = chk_noncanon;
  assign chk.addr               = chk_addr;
  assign chk.size               = chk_size;
  // alignment checking needs both the control mask and the flags bit
  assign chk.ac_enable          = ctrl_q[CTRL_AC_BIT] & chk_flag_ac;
  assign chk.unaligned          = chk_unaligned;
  assign chk.cpl                = chk_cpl;
  assign chk.page_fault         = chk_page_fault;

  slfc_judge u_judge (
    .c (chk.checker_end)
  );

  // ------------------------------------------------------------
  // verdict register
  // ------------------------------------------------------------
  // a core in shutdown executes nothing, so checks are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_valid_q <= 1'b0;
      fault_kind_q  <= FLT_NONE;
      fault_err_q   <= 1'b0;
    end else if (chk_valid && !shutdown_q) begin
      fault_valid_q <= (chk.fault != FLT_NONE);
      fault_kind_q  <= chk.fault;
      fault_err_q   <= chk.err_zero;
    end else begin
      fault_valid_q <= 1'b0;
      fault_kind_q  <= FLT_NONE;
      fault_err_q   <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_fault_q <= FLT_NONE;
      fault_cnt_q  <= 16'h0000;
    end else if (chk_valid && !shutdown_q && chk.fault != FLT_NONE) begin
      last_fault_q <= chk.fault;
      fault_cnt_q  <= fault_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // nmi pin synchroniser
  // ------------------------------------------------------------
  // level moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_sync_q  <= 3'b000;
      nmi_level_q <= 1'b0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin};
      if (nmi_sync_q[1] == nmi_sync_q[2]) begin
        nmi_level_q <= nmi_sync_q[2];
      end
    end
  end

  assign nmi_edge = (nmi_sync_q[1] == nmi_sync_q[2]) && nmi_sync_q[2] && !nmi_level_q;

  // ------------------------------------------------------------
  // nmi masking
  // ------------------------------------------------------------
  // an nmi seen while masked is held, not lost, until the return
  always_comb begin
    nmi_blocked_d = nmi_blocked_q;
    if (interrupt_return_instr_retire) begin
      nmi_blocked_d = 1'b0;
    end
    if ((nmi_edge || nmi_pend_q) && !nmi_blocked_q && !shutdown_q) begin
      nmi_blocked_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_blocked_q <= 1'b0;
      nmi_take_q    <= 1'b0;
    end else begin
      nmi_blocked_q <= nmi_blocked_d;
      nmi_take_q    <= (nmi_edge || nmi_pend_q) && !nmi_blocked_q && !shutdown_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge && nmi_blocked_q) begin
      nmi_pend_q <= 1'b1;
    end else if (!nmi_blocked_q && !shutdown_q) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // vector limit check
  // ------------------------------------------------------------
  function automatic logic beyond(input logic [7:0] v, input logic [15:0] lim);
    logic [18:0] last_b;
    last_b = 19'(v) * 19'(ENTRY_B) + 19'(ENTRY_B - 1);
    return last_b > {3'b000, lim};
  endfunction

  always_comb begin
    dlv_d = dlv_q;
    case (dlv_q)
      DLV_IDLE: begin
        if (vec_req && beyond(vec_num, idt_limit_q)) begin
          dlv_d = DLV_DCHK;
        end
      end
      DLV_DCHK: begin
        if (beyond(DF_VECTOR, idt_limit_q)) begin
          dlv_d = DLV_SHUT;
        end else begin
          dlv_d = DLV_IDLE;
        end
      end
      DLV_SHUT: begin
        dlv_d = DLV_SHUT;
      end
      default: begin
        dlv_d = DLV_IDLE;
      end
    endcase
  end

  // only reset leaves shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlv_q      <= DLV_IDLE;
      vec_hold_q <= 8'h00;
      vec_ok_q   <= 1'b0;
      df_q       <= 1'b0;
      vec_busy_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else begin
      dlv_q      <= dlv_d;
      vec_ok_q   <= (dlv_q == DLV_IDLE) && vec_req && !beyond(vec_num, idt_limit_q);
      df_q       <= (dlv_q == DLV_DCHK) && !beyond(DF_VECTOR, idt_limit_q);
      vec_busy_q <= (dlv_d != DLV_IDLE);
      shutdown_q <= (dlv_d == DLV_SHUT);
      if (dlv_q == DLV_IDLE && vec_req) begin
        vec_hold_q <= vec_num;
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // zero wait: ready rises in the access phase of every transfer
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready_q && pwrite;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == CTRL_OFF[ADDR_W-1:0]) begin
      rd_word[CTRL_EM_BIT] = ctrl_q[CTRL_EM_BIT];
      rd_word[CTRL_TS_BIT] = ctrl_q[CTRL_TS_BIT];
      rd_word[CTRL_AC_BIT] = ctrl_q[CTRL_AC_BIT];
    end else if (paddr == IDTL_OFF[ADDR_W-1:0]) begin
      rd_word[15:0] = idt_limit_q;
    end else if (paddr == STAT_OFF[ADDR_W-1:0]) begin
      rd_word[3:0]   = last_fault_q;
      rd_word[4]     = nmi_blocked_q;
      rd_word[5]     = nmi_pend_q;
      rd_word[6]     = shutdown_q;
      rd_word[7]     = vec_busy_q;
      rd_word[15:8]  = vec_hold_q;
    end else if (paddr == FCNT_OFF[ADDR_W-1:0]) begin
      rd_word[15:0] = fault_cnt_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_setup;
      prdata_q  <= (apb_setup && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr_q <= apb_setup && !rd_hit;
    end
  end

  // writes to status or counter are ignored without pslverr; writes to holes are ignored and flagged by pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= CTRL_RST;
      idt_limit_q <= IDTL_RST;
    end else if (apb_wr && paddr == CTRL_OFF[ADDR_W-1:0] && pstrb[0]) begin
      ctrl_q[CTRL_EM_BIT] <= pwdata[CTRL_EM_BIT];
      ctrl_q[CTRL_TS_BIT] <= pwdata[CTRL_TS_BIT];
      ctrl_q[CTRL_AC_BIT] <= pwdata[CTRL_AC_BIT];
    end else if (apb_wr && paddr == IDTL_OFF[ADDR_W-1:0]) begin
      if (pstrb[0]) begin
        idt_limit_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        idt_limit_q[15:8] <= pwdata[15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pready         = pready_q;
  assign prdata         = prdata_q;
  assign pslverr        = pslverr_q;
  assign fault_valid    = fault_valid_q;
  assign fault_kind     = fault_kind_q;
  assign fault_err_zero = fault_err_q;
  assign nmi_take       = nmi_take_q;
  assign nmi_blocked    = nmi_blocked_q;
  assign vec_ok         = vec_ok_q;
  assign double_fault   = df_q;
  assign vec_busy       = vec_busy_q;
  assign shutdown       = shutdown_q;

endmodule

/* slfc_pkg.sv */
// Purpose: shared constants and types of the simd legacy fault check block
// Assumes: one core clock, apb register access
// Notes:   offsets are byte addresses of aligned 32-bit words

package slfc_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF    = 12'h000;
  localparam logic [11:0] IDTL_OFF    = 12'h004;
  localparam logic [11:0] STAT_OFF    = 12'h008;
  localparam logic [11:0] FCNT_OFF    = 12'h00C;
  localparam int          CTRL_EM_BIT = 2;
  localparam int          CTRL_TS_BIT = 3;
  localparam int          CTRL_AC_BIT = 4;
  localparam logic [2:0]  CTRL_RST    = 3'h0;
  localparam logic [15:0] IDTL_RST    = 16'hFFFF;

  // --------------------------------------------------------------
  // architectural constants
  // --------------------------------------------------------------
  localparam logic [7:0]  LOCK_PREFIX = 8'hF0;
  localparam logic [1:0]  MOD_REG     = 2'b11;
  localparam logic [32:0] REAL_LIMIT  = 33'h0_0000_FFFF;
  localparam logic [1:0]  CPL_USER    = 2'd3;

  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_V86  = 2'b01,
    MODE_PROT = 2'b10,
    MODE_LONG = 2'b11
  } slfc_mode_t;

  typedef enum logic [2:0] {
    INS_OTHER = 3'b000,
    INS_MQS   = 3'b001,
    INS_NTQS  = 3'b010,
    INS_RQM   = 3'b011
  } slfc_instr_t;

  typedef enum logic [3:0] {
    FLT_NONE = 4'h0,
    FLT_UD   = 4'h1,
    FLT_NM   = 4'h2,
    FLT_MF   = 4'h3,
    FLT_SS   = 4'h4,
    FLT_GP   = 4'h5,
    FLT_PF   = 4'h6,
    FLT_AC   = 4'h7
  } slfc_fault_t;

  typedef enum logic [1:0] {
    DLV_IDLE = 2'b00,
    DLV_DCHK = 2'b01,
    DLV_SHUT = 2'b10
  } slfc_dlv_t;

endpackage

/* slfc_chk_if.sv */
`timescale 1ns/1ns
// Purpose: carries one instruction's check inputs and the verdict
// Assumes: all signals on pclk
// Notes:   driven by the top, judged by the checker
interface slfc_chk_if;
  import slfc_pkg::*;
  slfc_mode_t  mode;
  slfc_instr_t instr;
  logic        has_mem;
  logic [7:0]  prefix;
  logic        feature_ok;
  logic [1:0]  mod_field;
  logic        emulation_flag;
  logic        task_switched_flag;
  logic        fpu_pending;
  logic        stack_ref;
  logic        seg_illegal;
  logic        dst_nonwr;
  logic        null_sel;
  logic        noncanon;
  logic [31:0] addr;
  logic [3:0]  size;
  logic        ac_enable;
  logic        unaligned;
  logic [1:0]  cpl;
  logic        page_fault;
  slfc_fault_t fault;
  logic        err_zero;

  modport core (output mode, instr, has_mem, prefix, feature_ok, mod_field,
                emulation_flag, task_switched_flag, fpu_pending, stack_ref,
                seg_illegal, dst_nonwr, null_sel, noncanon, addr, size,
                ac_enable, unaligned, cpl, page_fault,
                input fault, err_zero);
  modport checker_end (input mode, instr, has_mem, prefix, feature_ok, mod_field,
                emulation_flag, task_switched_flag, fpu_pending, stack_ref,
                seg_illegal, dst_nonwr, null_sel, noncanon, addr, size,
                ac_enable, unaligned, cpl, page_fault,
                output fault, err_zero);
endinterface

/* slfc_judge.sv */
`timescale 1ns/1ns
// Purpose: priority fault judgement for one covered instruction
// Assumes: inputs stable for the cycle of the check
// Notes:   purely combinational; the top registers the verdict
module slfc_judge
  import slfc_pkg::*;
(
  slfc_chk_if.checker_end c
);

  logic [32:0] end_addr;
  logic        ud_hit;
  logic        ac_hit;

  always_comb begin
    end_addr = {1'b0, c.addr} + {29'h0, c.size} - 33'h1;
    ud_hit = c.emulation_flag
          || (c.instr == INS_MQS && c.mod_field != MOD_REG)
          || (c.prefix == LOCK_PREFIX)
          || !c.feature_ok;
    ac_hit = c.ac_enable && c.unaligned && c.cpl == CPL_USER && c.mode != MODE_REAL;
    c.fault = FLT_NONE;
    c.err_zero = 1'b0;
    if (ud_hit) begin
      c.fault = FLT_UD;
    end else if (c.task_switched_flag) begin
      c.fault = FLT_NM;
    end else if (c.fpu_pending) begin
      c.fault = FLT_MF;
    end else if (c.has_mem) begin
      if (c.mode == MODE_PROT && c.seg_illegal && c.stack_ref) begin
        c.fault = FLT_SS;
        c.err_zero = 1'b1;
      end else if (c.mode == MODE_PROT && c.seg_illegal) begin
        c.fault = FLT_GP;
        c.err_zero = 1'b1;
      end else if (c.mode == MODE_PROT && c.dst_nonwr
                   && (c.instr == INS_MQS || c.instr == INS_RQM)) begin
        c.fault = FLT_GP;
      end else if (c.mode == MODE_PROT && c.null_sel && c.instr == INS_MQS) begin
        c.fault = FLT_GP;
      end else if (c.mode == MODE_LONG && c.noncanon && c.stack_ref) begin
        c.fault = FLT_SS;
        c.err_zero = 1'b1;
      end else if (c.mode == MODE_LONG && c.noncanon) begin
        c.fault = FLT_GP;
        c.err_zero = 1'b1;
      end else if ((c.mode == MODE_REAL || c.mode == MODE_V86)
                   && end_addr > REAL_LIMIT) begin
        c.fault = FLT_GP;
      end else if (c.mode != MODE_REAL && c.page_fault) begin
        c.fault = FLT_PF;
      end else if (ac_hit) begin
        c.fault = FLT_AC;
        c.err_zero = 1'b1;
      end
    end
  end

endmodule

/* slfc_monitor.sv */
`timescale 1ns/1ns
// Purpose: port level checks of the fault check top
// Assumes: one pclk domain, async active low reset
// Notes:   bound into every slfc_top instance
module slfc_monitor
  import slfc_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // check path
  input wire logic        chk_valid,
  input wire slfc_instr_t chk_instr,
  input wire logic        chk_has_mem,
  input wire logic [7:0]  chk_prefix,
  input wire logic        chk_feature_ok,
  input wire logic [1:0]  chk_mod_field,
  input wire logic        fault_valid,
  input wire slfc_fault_t fault_kind,
  // nmi and vectors
  input wire logic        interrupt_return_instr_retire,
  input wire logic        nmi_take,
  input wire logic        nmi_blocked,
  input wire logic        vec_req,
  input wire logic        vec_ok,
  input wire logic        double_fault,
  input wire logic        vec_busy,
  input wire logic        shutdown
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------
  // sequences
  // ----------
  sequence s_taken;
    chk_valid && !shutdown;
  endsequence
  sequence s_vec;
    vec_req && !vec_busy && !shutdown;
  endsequence
  // ----------
  // assertions
  // ----------
  a_lock_undef: assert property (s_taken ##0 chk_prefix == LOCK_PREFIX
    |=> fault_kind == FLT_UD)
    else $error("lock prefix gave no undefined opcode");
  a_feature_undef: assert property (s_taken ##0 !chk_feature_ok
    |=> fault_valid && fault_kind == FLT_UD)
    else $error("missing feature gave no undefined opcode");
  a_form_undef: assert property (s_taken ##0
    (chk_instr == INS_MQS && chk_mod_field != MOD_REG) |=> fault_kind == FLT_UD)
    else $error("masked store memory form gave no undefined opcode");
  a_nomem_kinds: assert property (s_taken ##0 !chk_has_mem
    |=> fault_kind inside {FLT_NONE, FLT_UD, FLT_NM, FLT_MF})
    else $error("memory fault without memory operand");
  a_nmi_hold: assert property (nmi_blocked && !interrupt_return_instr_retire |=> nmi_blocked)
    else $error("nmi mask dropped without interrupt return");
  a_nmi_sets: assert property (nmi_take |-> nmi_blocked)
    else $error("nmi taken without masking");
  a_vec_answer: assert property (s_vec |=> vec_ok || vec_busy)
    else $error("vector request unanswered");
  a_df_after: assert property (double_fault |-> $past(vec_busy))
    else $error("double fault without limit check");
  a_busy_step: assert property (vec_busy |=> double_fault || shutdown)
    else $error("limit check ended without outcome");
  a_shut_sticky: assert property (shutdown |=> shutdown)
    else $error("shutdown left without reset");
  a_shut_quiet: assert property ($past(shutdown) |-> !fault_valid && !vec_ok && !double_fault)
    else $error("activity during shutdown");
endmodule

bind slfc_top slfc_monitor mon (.*);

/* slfc_decoder_model.sv */
`timescale 1ns/1ns
// Purpose: decoder and pipeline stand-in feeding the fault checks
// Assumes: one request per issue call, launched after a pclk edge
// Notes:   on release addr, size, prefix, noncanon and seg_illegal are inverted so stale values never pass as live
module slfc_decoder_model
  import slfc_pkg::*;
(
  // clock
  input wire logic    pclk,
  // check request
  output logic        chk_valid,
  output slfc_mode_t  chk_mode,
  output slfc_instr_t chk_instr,
  output logic        chk_has_mem,
  output logic [7:0]  chk_prefix,
  output logic        chk_feature_ok,
  output logic [1:0]  chk_mod_field,
  output logic        chk_fpu_pending,
  output logic        chk_stack_ref,
  output logic        chk_seg_illegal,
  output logic        chk_dst_nonwr,
  output logic        chk_null_sel,
  output logic        chk_noncanon,
  output logic [31:0] chk_addr,
  output logic [3:0]  chk_size,
  output logic        chk_flag_ac,
  output logic        chk_unaligned,
  output logic [1:0]  chk_cpl,
  output logic        chk_page_fault,
  // retirement
  output logic        interrupt_return_instr_retire
);
  initial begin
    {chk_valid, chk_has_mem, chk_prefix, chk_feature_ok, chk_mod_field, interrupt_return_instr_retire} = '0;
    {chk_addr, chk_size, chk_cpl, chk_fpu_pending, chk_stack_ref, chk_seg_illegal} = '0;
    {chk_dst_nonwr, chk_null_sel, chk_noncanon, chk_flag_ac, chk_unaligned} = '0;
    chk_page_fault = 1'b0;
    chk_mode = MODE_REAL;
    chk_instr = INS_OTHER;
  end
  // f: 12 mem, 11 page, 10 unal, 9 ac, 8 noncanon, 7 null, 6 nonwr,
  //    5 seg, 4 stack, 3 fpu, 2 memory form, 1 feature off, 0 lock
  task automatic issue(input slfc_mode_t m, input slfc_instr_t i, input logic [12:0] f,
                       input logic [31:0] a, input logic [3:0] s, input logic [1:0] c);
    @(posedge pclk);
    chk_valid <= 1'b1;
    chk_mode <= m;
    chk_instr <= i;
    chk_has_mem <= f[12];
    chk_prefix <= f[0] ? LOCK_PREFIX : 8'h66;
    chk_feature_ok <= !f[1];
    chk_mod_field <= f[2] ? 2'b00 : MOD_REG;
    {chk_page_fault, chk_unaligned, chk_flag_ac, chk_noncanon, chk_null_sel, chk_dst_nonwr,
     chk_seg_illegal, chk_stack_ref, chk_fpu_pending} <= f[11:3];
    {chk_addr, chk_size, chk_cpl} <= {a, s, c};
    @(posedge pclk);
    chk_valid <= 1'b0;
    {chk_addr, chk_size, chk_prefix, chk_noncanon, chk_seg_illegal} <=
      ~{chk_addr, chk_size, chk_prefix, chk_noncanon, chk_seg_illegal};
  endtask
  task automatic interrupt_return_instr;
    @(posedge pclk) interrupt_return_instr_retire <= 1'b1;
    @(posedge pclk) interrupt_return_instr_retire <= 1'b0;
  endtask
endmodule

/* tb.sv */
`timescale 1ns/1ns
// Purpose: self-checking bench of the fault check top
// Assumes: decoder model feeds checks, bench drives apb, nmi and vectors
// Notes:   shutdown is entered last, as only reset leaves it
module tb;
  import slfc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, chk_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, chk_addr, rv, ca;
  logic [3:0]  pstrb, chk_size, cs;
  logic [7:0]  chk_prefix, vec_num;
  logic [1:0]  chk_mod_field, chk_cpl, cc;
  logic        chk_has_mem, chk_feature_ok, chk_fpu_pending, chk_stack_ref, chk_seg_illegal;
  logic        chk_dst_nonwr, chk_null_sel, chk_noncanon, chk_flag_ac, chk_unaligned;
  logic        chk_page_fault, fault_valid, fault_err_zero, nmi_pin, interrupt_return_instr_retire, nmi_take;
  logic        nmi_blocked, vec_req, vec_ok, double_fault, vec_busy, shutdown, ev, t;
  slfc_mode_t  chk_mode;
  slfc_instr_t chk_instr;
  slfc_fault_t fault_kind;
  int          n_mismatch, checks;

  slfc_top dut (.*);
  slfc_decoder_model dec (.*);

  always #2 pclk = ~pclk;

  task cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
    @(posedge pclk);
    penable <= 1'b1;
    // ready is sampled at rising edges; no cycle count assumed, only the bound
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: apb ready never came", $time);
    end
    {rv, ev} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task ck(input slfc_mode_t m, input slfc_instr_t i, input logic [12:0] f,
          input slfc_fault_t k, input logic ez);
    dec.issue(m, i, f, ca, cs, cc);
    #1;
    cmp(fault_kind, k);
    cmp(fault_valid, k != FLT_NONE);
    if (ez !== 1'bx) cmp(fault_err_zero, ez);
  endtask
  task wt;
    t = 0;
    repeat (8) begin
      @(posedge pclk);
      #1;
      if (nmi_take === 1'b1) t = 1;
    end
  endtask
  task vq(input logic [7:0] v);
    @(posedge pclk) {vec_req, vec_num} <= {1'b1, v};
    @(posedge pclk) {vec_req, vec_num} <= {1'b0, ~v};
    #1;
  endtask
  task final_report;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {nmi_pin, vec_req, vec_num, ca, cc} = '0;
    cs = 4'h8;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CTRL_OFF, 0); cmp(rv, 0);
    apb(0, IDTL_OFF, 0); cmp(rv, 32'h0000_FFFF);
    apb(0, 12'h010, 0); cmp({rv[30:0], ev}, 1);
    ck(MODE_LONG, INS_OTHER, 13'h1001, FLT_UD, 1'bx);
    ck(MODE_REAL, INS_OTHER, 13'h0002, FLT_UD, 1'bx);
    ck(MODE_PROT, INS_MQS, 13'h1004, FLT_UD, 1'bx);
    ck(MODE_PROT, INS_MQS, 13'h1000, FLT_NONE, 1'bx);
    ck(MODE_V86, INS_OTHER, 13'h1008, FLT_MF, 1'bx);
    ck(MODE_PROT, INS_OTHER, 13'h1030, FLT_SS, 1'b1);
    ck(MODE_LONG, INS_OTHER, 13'h1110, FLT_SS, 1'b1);
    ck(MODE_PROT, INS_OTHER, 13'h1020, FLT_GP, 1'b1);
    ck(MODE_PROT, INS_RQM, 13'h1040, FLT_GP, 1'bx);
    ck(MODE_PROT, INS_NTQS, 13'h1040, FLT_NONE, 1'bx);
    ck(MODE_PROT, INS_MQS, 13'h1080, FLT_GP, 1'bx);
    ck(MODE_LONG, INS_OTHER, 13'h1100, FLT_GP, 1'b1);
    ck(MODE_PROT, INS_OTHER, 13'h0130, FLT_NONE, 1'bx);
    {ca, cs} = {32'h0000_FFFF, 4'h1};
    ck(MODE_REAL, INS_OTHER, 13'h1000, FLT_NONE, 1'bx);
    cs = 4'h2;
    ck(MODE_V86, INS_OTHER, 13'h1000, FLT_GP, 1'bx);
    {ca, cs, cc} = {32'h0000_0001, 4'h8, 2'd3};
    ck(MODE_V86, INS_OTHER, 13'h1800, FLT_PF, 1'b0);
    apb(1, CTRL_OFF, 32'h0000_0008);
    ck(MODE_PROT, INS_OTHER, 13'h1020, FLT_NM, 1'b0);
    apb(1, CTRL_OFF, 32'h0000_0010);
    ck(MODE_V86, INS_OTHER, 13'h1600, FLT_AC, 1'b1);
    ck(MODE_REAL, INS_OTHER, 13'h1600, FLT_NONE, 1'bx);
    cc = 2'd2;
    ck(MODE_LONG, INS_OTHER, 13'h1600, FLT_NONE, 1'bx);
    apb(1, CTRL_OFF, 32'h0000_0004);
    ck(MODE_REAL, INS_OTHER, 13'h0000, FLT_UD, 1'bx);
    ck(MODE_LONG, INS_NTQS, 13'h1000, FLT_UD, 1'bx);
    @(posedge pclk) nmi_pin <= 1'b1;
    wt; cmp({t, nmi_blocked}, 2'b11);
    @(posedge pclk) nmi_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    nmi_pin <= 1'b1;
    wt; cmp({t, nmi_blocked}, 2'b01);
    dec.interrupt_return_instr;
    wt; cmp(t, 1);
    dec.interrupt_return_instr;
    wt; cmp({t, nmi_blocked}, 2'b00);
    // limit 4F: vector 9 ends exactly on it, 10 is past it
    apb(1, IDTL_OFF, 32'h0000_004F);
    vq(9); cmp(vec_ok, 1);
    vq(10); cmp({vec_ok, vec_busy}, 2'b01);
    @(posedge pclk);
    #1 cmp({double_fault, shutdown}, 2'b10);
    apb(1, IDTL_OFF, 32'h0000_0046);
    vq(20);
    @(posedge pclk);
    #1 cmp({double_fault, shutdown}, 2'b01);
    ck(MODE_LONG, INS_OTHER, 13'h1001, FLT_NONE, 1'bx);
    vq(1); cmp({vec_ok, shutdown}, 2'b01);
    apb(0, STAT_OFF, 0); cmp(rv, 32'h0000_14C1);
    final_report;
  end

  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end
endmodule
